// file: logic/stoc_pkg.sv
// Purpose: Shared constants for supply trigger, output and list control.
// Assumes: 200 MHz clock; register port with one-cycle read latency.
// Notes: Set-point values are 16-bit signed DAC codes.
package stoc_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int VAL_W = 16;
	localparam int CNT_W = 8;
	localparam int IDX_W = 10;
	localparam int DWELL_W = 15;
	localparam int TICK_W = 17;
	localparam int LIST_MAX_ENTRIES = 1002;
	// Register offsets
	localparam logic [ADDR_W-1:0] A_CMD = 8'h00;
	localparam logic [ADDR_W-1:0] A_CAL = 8'h04;
	localparam logic [ADDR_W-1:0] A_PROT = 8'h08;
	localparam logic [ADDR_W-1:0] A_CONT = 8'h0C;
	localparam logic [ADDR_W-1:0] A_OUTPUT_ENABLE_STATE = 8'h10;
	localparam logic [ADDR_W-1:0] A_FUNC = 8'h14;
	localparam logic [ADDR_W-1:0] A_TMODE = 8'h18;
	localparam logic [ADDR_W-1:0] A_PMODE = 8'h1C;
	localparam logic [ADDR_W-1:0] A_VSET = 8'h20;
	localparam logic [ADDR_W-1:0] A_ISET = 8'h24;
	localparam logic [ADDR_W-1:0] A_VTRIG = 8'h28;
	localparam logic [ADDR_W-1:0] A_ITRIG = 8'h2C;
	localparam logic [ADDR_W-1:0] A_LCOUNT = 8'h30;
	localparam logic [ADDR_W-1:0] A_LSKIP = 8'h34;
	localparam logic [ADDR_W-1:0] A_LDIR = 8'h38;
	localparam logic [ADDR_W-1:0] A_LGEN = 8'h3C;
	localparam logic [ADDR_W-1:0] A_LPTS = 8'h40;
	localparam logic [ADDR_W-1:0] A_LDWELL = 8'h44;
	localparam logic [ADDR_W-1:0] A_MEASV = 8'h48;
	localparam logic [ADDR_W-1:0] A_MEASI = 8'h4C;
	localparam logic [ADDR_W-1:0] A_STATUS = 8'h50;
	// Command register bits
	localparam int CB_CAL_ZERO = 0;
	localparam int CB_ARM = 1;
	localparam int CB_TRIG = 2;
	localparam int CB_LIST_CLR = 3;
	localparam int CB_STOP = 4;
	localparam int CB_RST = 5;
	localparam int CB_REMOTE = 6;
	localparam int CB_LOCAL = 7;
	// Field positions
	localparam int CAL_STAT_BIT = 0;
	localparam int CAL_SEL_LSB = 1;
	localparam int PM_V_LSB = 0;
	localparam int PM_I_LSB = 2;
	localparam int ST_ARMED = 0;
	localparam int ST_ERR = 1;
	localparam int ST_RUN = 2;
	localparam int ST_IDX_LSB = 8;
	localparam int MEAS_EXP_LSB = 16;
	// Encodings and reset values
	localparam logic [1:0] PM_PROGRAM_MODE_A = 2'h0;
	localparam logic [1:0] PM_TRANSIENT_PROGRAM_MODE = 2'h1;
	localparam logic [1:0] PM_LIST = 2'h2;
	localparam logic [1:0] SEL_NONE = 2'h0;
	localparam logic [1:0] SEL_POS = 2'h1;
	localparam logic [1:0] SEL_NEG = 2'h2;
	localparam logic MODE_VOLT = 1'b0;
	localparam logic DIR_UP = 1'b0;
	localparam logic GEN_DEFAULT_SEQUENCE = 1'b0;
	localparam logic [CNT_W-1:0] COUNT_RST = 8'h01;
	localparam logic [CNT_W-1:0] SKIP_RST = 8'h00;
	localparam logic [7:0] MEAS_EXP = 8'hFD;
	// Timing
	localparam int CLK_FREQ_MHZ = 200;
	localparam int DWELL_MIN_US = 500;
	localparam int DWELL_MAX_S = 10;
	localparam int TICK_CYC = CLK_FREQ_MHZ * DWELL_MIN_US;
	localparam int DWELL_MAX_TICKS = DWELL_MAX_S * 1000000 / DWELL_MIN_US;

	function automatic logic reg_hit(input logic en,
		input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
		return en && (a == b);
	endfunction

	function automatic logic [VAL_W-1:0] gate_val(input logic en,
		input logic [VAL_W-1:0] v);
		return en ? v : '0;
	endfunction
endpackage

// file: logic/stoc_list_if.sv
// Purpose: Control and status path between main block and list sequencer.
// Assumes: Single clock domain.
// Notes: ctrl drives settings and strobes, seq returns progress.
`timescale 1ns/10ps
interface stoc_list_if import stoc_pkg::*; ();
	logic start;
	logic stop;
	logic dir;
	logic tick;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] skip;
	logic [IDX_W-1:0] last;
	logic [DWELL_W-1:0] dwell;
	logic running;
	logic step;
	logic [IDX_W-1:0] index;
	modport ctrl(output start, stop, dir, tick, count, skip, last, dwell,
		input running, step, index);
	modport seq(input start, stop, dir, tick, count, skip, last, dwell,
		output running, step, index);
endinterface

// file: logic/stoc_list_seq.sv
// Purpose: Steps a list index through passes with dwell, repeat and skip.
// Assumes: tick is a one-cycle pulse every minimum dwell unit.
// Notes: Settings are sampled live; change them only while idle.
`timescale 1ns/10ps
module stoc_list_seq import stoc_pkg::*; (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Control path
	stoc_list_if.seq lst
);
	typedef enum logic [1:0] {
		S_IDLE = 2'b01,
		S_RUN = 2'b10
	} stoc_seq_state_t;

	stoc_seq_state_t state_r, state_nxt;
	logic [IDX_W-1:0] idx_r, idx_nxt;
	logic [CNT_W-1:0] pass_r, pass_nxt;
	logic [DWELL_W-1:0] dw_r, dw_nxt;
	logic step_r, step_nxt;
	logic expire, wrap, done;
	logic [IDX_W-1:0] first_idx;

	assign expire = lst.tick && (DWELL_W'(dw_r + 1'b1) >= lst.dwell);
	assign wrap = (lst.dir == DIR_UP) ? (idx_r == lst.last) : (idx_r == '0);
	assign done = (lst.count != '0) && (CNT_W'(pass_r + 1'b1) == lst.count);
	// Skip larger than the list is ignored
	assign first_idx = (IDX_W'(lst.skip) > lst.last) ? '0 : IDX_W'(lst.skip);

	always_comb begin
		state_nxt = state_r;
		idx_nxt = idx_r;
		pass_nxt = pass_r;
		dw_nxt = dw_r;
		step_nxt = 1'b0;
		unique case (state_r)
			S_IDLE: begin
				if (lst.start) begin
					state_nxt = S_RUN;
					pass_nxt = '0;
					dw_nxt = '0;
					idx_nxt = (lst.dir == DIR_UP) ? '0 : lst.last;
				end
			end
			S_RUN: begin
				if (lst.stop) begin
					state_nxt = S_IDLE;
				end else if (expire) begin
					dw_nxt = '0;
					step_nxt = 1'b1;
					if (!wrap) begin
						idx_nxt = (lst.dir == DIR_UP) ? IDX_W'(idx_r + 1'b1)
							: IDX_W'(idx_r - 1'b1);
					end else if (done) begin
						state_nxt = S_IDLE;
					end else begin
						pass_nxt = CNT_W'(pass_r + 1'b1);
						idx_nxt = (lst.dir == DIR_UP) ? first_idx
							: lst.last;
					end
				end else if (lst.tick) begin
					dw_nxt = DWELL_W'(dw_r + 1'b1);
				end
			end
			default: state_nxt = S_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= S_IDLE;
			idx_r <= '0;
			pass_r <= '0;
			dw_r <= '0;
			step_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			idx_r <= idx_nxt;
			pass_r <= pass_nxt;
			dw_r <= dw_nxt;
			step_r <= step_nxt;
		end
	end

	assign lst.running = (state_r == S_RUN);
	assign lst.index = idx_r;
	assign lst.step = step_r;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_seq_stop;
		lst.running && lst.stop |=> !lst.running;
	endproperty
	a_seq_stop: assert property (p_seq_stop)
		else $error("list kept running after stop");

	property p_skip_wrap;
		lst.running && !lst.stop && expire && wrap && !done
			&& lst.dir == DIR_UP |=> lst.index == $past(first_idx);
	endproperty
	a_skip_wrap: assert property (p_skip_wrap)
		else $error("repeat pass did not start after skipped steps");

	property p_down_wrap;
		lst.running && !lst.stop && expire && wrap && !done
			&& lst.dir != DIR_UP |=> lst.index == $past(lst.last);
	endproperty
	a_down_wrap: assert property (p_down_wrap)
		else $error("reverse pass did not restart at last entry");

	c_list_done: cover property (lst.running ##1 !lst.running);
endmodule

// file: logic/stoc_top.sv
// Purpose: Command control of supply trigger, output enable and list run.
// Assumes: Register port strobes are one cycle; inputs synchronous.
// Notes: Read data appear only in the cycle after the read strobe.
// Contract
// - Protect-limit select only in calibrate; max positive.
// - Calibration zero sets voltage and current zero.
// - Armed trigger loads stored trigger voltage, current.
// - Consumed trigger ignores more until re-armed.
// - Continuous arm keeps armed; single arm redundant.
// - Device reset command sets continuous arm on.
// - Continuous-arm query returns one or zero.
// - Measurement queries return measured value with exponent.
// - Power-up output on; entering remote turns off.
// - Disable saves values, programs zero, keeps readable.
// - Enable reloads saved voltage and current.
// - Output-state query returns zero off, one on.
// - Mode picks limit; crossing other limit flags error.
// - Mode writes force transient program modes program_mode_a.
// - Mode queries return zero voltage, one current.
// - Trigger switches to stored trigger operating mode.
// - List clear resets pointers, direction, sequence, count.
// - Count 0..255; zero repeats until program_mode_a/stop.
// - Direction picks first-to-last or last-to-first.
// - Later passes skip first n steps.
// - Skip only works in forward direction.
// - Clear zeroes skip; queries return stored values.
// - List holds at most 1002 entries.
// - Each step dwells 0.0005 to 10 seconds.
`timescale 1ns/10ps
module stoc_top import stoc_pkg::*; #(
	parameter int TICK_CYC_P = TICK_CYC
) (
	// Clock and reset
	input wire logic REF_CLK_I,
	input wire logic RST_N_I,
	// Register port
	input wire logic [ADDR_W-1:0] ADDR_I,
	input wire logic [DATA_W-1:0] WR_DATA_I,
	input wire logic WR_EN_I,
	input wire logic RD_EN_I,
	output logic [DATA_W-1:0] RD_DATA_O,
	// Trigger and analog status
	input wire logic TRIG_I,
	input wire logic V_LIMIT_I,
	input wire logic I_LIMIT_I,
	input wire logic [VAL_W-1:0] MEAS_V_I,
	input wire logic [VAL_W-1:0] MEAS_I_I,
	// Output programming
	output logic [VAL_W-1:0] V_PROG_O,
	output logic [VAL_W-1:0] I_PROG_O,
	output logic OUT_EN_O,
	output logic MODE_CURR_O,
	output logic [1:0] PROT_SEL_O,
	output logic LIMIT_ERR_O,
	output logic ARMED_O,
	// List progress
	output logic LIST_RUN_O,
	output logic LIST_STEP_O,
	output logic [IDX_W-1:0] LIST_INDEX_O
);
	stoc_list_if lst();

	logic cal_stat_r, cal_stat_nxt;
	logic [1:0] prot_sel_r, prot_sel_nxt;
	logic cont_r, cont_nxt;
	logic single_r, single_nxt;
	logic armed_r, armed_nxt;
	logic remote_r, remote_nxt;
	logic out_en_r, out_en_nxt;
	logic func_r, func_nxt;
	logic tmode_r, tmode_nxt;
	logic [1:0] vpm_r, vpm_nxt;
	logic [1:0] ipm_r, ipm_nxt;
	logic [VAL_W-1:0] set_v_r, set_v_nxt;
	logic [VAL_W-1:0] set_i_r, set_i_nxt;
	logic [VAL_W-1:0] vtrig_r, vtrig_nxt;
	logic [VAL_W-1:0] itrig_r, itrig_nxt;
	logic [VAL_W-1:0] v_prog_r, v_prog_nxt;
	logic [VAL_W-1:0] i_prog_r, i_prog_nxt;
	logic [CNT_W-1:0] count_r, count_nxt;
	logic [CNT_W-1:0] skip_r, skip_nxt;
	logic dir_r, dir_nxt;
	logic gen_r, gen_nxt;
	logic [IDX_W:0] pts_r, pts_nxt;
	logic [DWELL_W-1:0] dwell_r, dwell_nxt;
	logic err_r, err_nxt;
	logic start_r, start_nxt;
	logic stop_r, stop_nxt;
	logic [DATA_W-1:0] rd_r, rd_nxt;
	logic [TICK_W-1:0] tick_cnt_r, tick_cnt_nxt;
	logic tick_r, tick_nxt;

	logic wr_cmd;
	logic c_zero, c_arm, c_trig, c_clr, c_stop, c_rst, c_remote, c_local;
	logic fire, lim_ev, wr_mode;
	logic [1:0] wr_vpm;

	assign wr_cmd = reg_hit(WR_EN_I, ADDR_I, A_CMD);
	assign c_zero = wr_cmd && WR_DATA_I[CB_CAL_ZERO];
	assign c_arm = wr_cmd && WR_DATA_I[CB_ARM];
	assign c_trig = wr_cmd && WR_DATA_I[CB_TRIG];
	assign c_clr = wr_cmd && WR_DATA_I[CB_LIST_CLR];
	assign c_stop = wr_cmd && WR_DATA_I[CB_STOP];
	assign c_rst = wr_cmd && WR_DATA_I[CB_RST];
	assign c_remote = wr_cmd && WR_DATA_I[CB_REMOTE];
	assign c_local = wr_cmd && WR_DATA_I[CB_LOCAL];
	assign fire = (TRIG_I || c_trig) && (cont_r || single_r);
	assign lim_ev = (func_r == MODE_VOLT) ? I_LIMIT_I : V_LIMIT_I;
	assign wr_mode = reg_hit(WR_EN_I, ADDR_I, A_FUNC)
		|| reg_hit(WR_EN_I, ADDR_I, A_TMODE);
	assign wr_vpm = WR_DATA_I[PM_V_LSB +: 2];

	// Control and set-point state
	always_comb begin
		cal_stat_nxt = cal_stat_r;
		prot_sel_nxt = prot_sel_r;
		cont_nxt = cont_r;
		single_nxt = single_r;
		remote_nxt = remote_r;
		out_en_nxt = out_en_r;
		func_nxt = func_r;
		tmode_nxt = tmode_r;
		vpm_nxt = vpm_r;
		ipm_nxt = ipm_r;
		set_v_nxt = set_v_r;
		set_i_nxt = set_i_r;
		vtrig_nxt = vtrig_r;
		itrig_nxt = itrig_r;
		count_nxt = count_r;
		skip_nxt = skip_r;
		dir_nxt = dir_r;
		gen_nxt = gen_r;
		pts_nxt = pts_r;
		dwell_nxt = dwell_r;
		start_nxt = 1'b0;
		stop_nxt = c_stop;
		if (reg_hit(WR_EN_I, ADDR_I, A_CAL)) begin
			cal_stat_nxt = WR_DATA_I[CAL_STAT_BIT];
			if (!WR_DATA_I[CAL_STAT_BIT]) begin
				prot_sel_nxt = SEL_NONE;
			end
		end
		if (reg_hit(WR_EN_I, ADDR_I, A_PROT) && cal_stat_r) begin
			prot_sel_nxt = WR_DATA_I[0] ? SEL_POS : SEL_NEG;
		end
		if (reg_hit(WR_EN_I, ADDR_I, A_CONT)) begin
			cont_nxt = WR_DATA_I[0];
		end
		if (c_rst) begin
			cont_nxt = 1'b1;
			dir_nxt = DIR_UP;
		end
		if (fire) begin
			single_nxt = 1'b0;
		end
		if (c_arm && !cont_r) begin
			single_nxt = 1'b1;
		end
		if (c_remote) begin
			remote_nxt = 1'b1;
			out_en_nxt = 1'b0;
		end
		if (c_local) begin
			remote_nxt = 1'b0;
			out_en_nxt = 1'b1;
		end
		if (reg_hit(WR_EN_I, ADDR_I, A_OUTPUT_ENABLE_STATE) && remote_r) begin
			out_en_nxt = WR_DATA_I[0];
		end
		if (reg_hit(WR_EN_I, ADDR_I, A_FUNC)) begin
			func_nxt = WR_DATA_I[0];
		end
		if (reg_hit(WR_EN_I, ADDR_I, A_TMODE)) begin
			tmode_nxt = WR_DATA_I[0];
		end
		if (wr_mode) begin
			if (vpm_r == PM_TRANSIENT_PROGRAM_MODE) begin
				vpm_nxt = PM_PROGRAM_MODE_A;
			end
			if (ipm_r == PM_TRANSIENT_PROGRAM_MODE) begin
				ipm_nxt = PM_PROGRAM_MODE_A;
			end
		end
		if (reg_hit(WR_EN_I, ADDR_I, A_PMODE)) begin
			vpm_nxt = wr_vpm;
			ipm_nxt = WR_DATA_I[PM_I_LSB +: 2];
			if (lst.running && wr_vpm == PM_PROGRAM_MODE_A) begin
				stop_nxt = 1'b1;
			end
			if (!lst.running && pts_r != '0 && (wr_vpm == PM_LIST
				|| WR_DATA_I[PM_I_LSB +: 2] == PM_LIST)) begin
				start_nxt = 1'b1;
			end
		end
		if (reg_hit(WR_EN_I, ADDR_I, A_VSET)) begin
			set_v_nxt = WR_DATA_I[VAL_W-1:0];
		end
		if (reg_hit(WR_EN_I, ADDR_I, A_ISET)) begin
			set_i_nxt = WR_DATA_I[VAL_W-1:0];
		end
		if (reg_hit(WR_EN_I, ADDR_I, A_VTRIG)) begin
			vtrig_nxt = WR_DATA_I[VAL_W-1:0];
		end
		if (reg_hit(WR_EN_I, ADDR_I, A_ITRIG)) begin
			itrig_nxt = WR_DATA_I[VAL_W-1:0];
		end
		if (fire) begin
			set_v_nxt = vtrig_r;
			set_i_nxt = itrig_r;
			func_nxt = tmode_r;
		end
		if (c_zero && cal_stat_r) begin
			set_v_nxt = '0;
			set_i_nxt = '0;
		end
		if (reg_hit(WR_EN_I, ADDR_I, A_LCOUNT)) begin
			count_nxt = WR_DATA_I[CNT_W-1:0];
		end
		if (reg_hit(WR_EN_I, ADDR_I, A_LSKIP)) begin
			skip_nxt = WR_DATA_I[CNT_W-1:0];
		end
		if (reg_hit(WR_EN_I, ADDR_I, A_LDIR)) begin
			dir_nxt = WR_DATA_I[0];
		end
		if (reg_hit(WR_EN_I, ADDR_I, A_LGEN)) begin
			gen_nxt = WR_DATA_I[0];
		end
		if (reg_hit(WR_EN_I, ADDR_I, A_LPTS)) begin
			pts_nxt = (WR_DATA_I > DATA_W'(LIST_MAX_ENTRIES))
				? (IDX_W+1)'(LIST_MAX_ENTRIES)
				: WR_DATA_I[IDX_W:0];
		end
		if (reg_hit(WR_EN_I, ADDR_I, A_LDWELL)) begin
			if (WR_DATA_I == '0) begin
				dwell_nxt = DWELL_W'(1);
			end else if (WR_DATA_I > DATA_W'(DWELL_MAX_TICKS)) begin
				dwell_nxt = DWELL_W'(DWELL_MAX_TICKS);
			end else begin
				dwell_nxt = WR_DATA_I[DWELL_W-1:0];
			end
		end
		if (c_clr) begin
			pts_nxt = '0;
			dir_nxt = DIR_UP;
			gen_nxt = GEN_DEFAULT_SEQUENCE;
			count_nxt = COUNT_RST;
			skip_nxt = SKIP_RST;
		end
		armed_nxt = cont_nxt || single_nxt;
		v_prog_nxt = gate_val(out_en_nxt, set_v_nxt);
		i_prog_nxt = gate_val(out_en_nxt, set_i_nxt);
		// Set wins over clear
		err_nxt = err_r && !(reg_hit(WR_EN_I, ADDR_I, A_STATUS)
			&& WR_DATA_I[ST_ERR]);
		if (lim_ev) begin
			err_nxt = 1'b1;
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			cal_stat_r <= 1'b0;
			prot_sel_r <= SEL_NONE;
			cont_r <= 1'b1;
			single_r <= 1'b0;
			armed_r <= 1'b1;
			remote_r <= 1'b0;
			out_en_r <= 1'b1;
			func_r <= MODE_VOLT;
			tmode_r <= MODE_VOLT;
			vpm_r <= PM_PROGRAM_MODE_A;
			ipm_r <= PM_PROGRAM_MODE_A;
			set_v_r <= '0;
			set_i_r <= '0;
			vtrig_r <= '0;
			itrig_r <= '0;
			v_prog_r <= '0;
			i_prog_r <= '0;
			count_r <= COUNT_RST;
			skip_r <= SKIP_RST;
			dir_r <= DIR_UP;
			gen_r <= GEN_DEFAULT_SEQUENCE;
			pts_r <= '0;
			dwell_r <= DWELL_W'(1);
			err_r <= 1'b0;
			start_r <= 1'b0;
			stop_r <= 1'b0;
		end else begin
			cal_stat_r <= cal_stat_nxt;
			prot_sel_r <= prot_sel_nxt;
			cont_r <= cont_nxt;
			single_r <= single_nxt;
			armed_r <= armed_nxt;
			remote_r <= remote_nxt;
			out_en_r <= out_en_nxt;
			func_r <= func_nxt;
			tmode_r <= tmode_nxt;
			vpm_r <= vpm_nxt;
			ipm_r <= ipm_nxt;
			set_v_r <= set_v_nxt;
			set_i_r <= set_i_nxt;
			vtrig_r <= vtrig_nxt;
			itrig_r <= itrig_nxt;
			v_prog_r <= v_prog_nxt;
			i_prog_r <= i_prog_nxt;
			count_r <= count_nxt;
			skip_r <= skip_nxt;
			dir_r <= dir_nxt;
			gen_r <= gen_nxt;
			pts_r <= pts_nxt;
			dwell_r <= dwell_nxt;
			err_r <= err_nxt;
			start_r <= start_nxt;
			stop_r <= stop_nxt;
		end
	end

	// Read port
	always_comb begin
		rd_nxt = '0;
		if (RD_EN_I) begin
			case (ADDR_I)
				A_CAL: rd_nxt = DATA_W'({prot_sel_r, cal_stat_r});
				A_PROT: rd_nxt = DATA_W'(prot_sel_r);
				A_CONT: rd_nxt = DATA_W'(cont_r);
				A_OUTPUT_ENABLE_STATE: rd_nxt = DATA_W'(out_en_r);
				A_FUNC: rd_nxt = DATA_W'(func_r);
				A_TMODE: rd_nxt = DATA_W'(tmode_r);
				A_PMODE: rd_nxt = DATA_W'({ipm_r, vpm_r});
				A_VSET: rd_nxt = DATA_W'(set_v_r);
				A_ISET: rd_nxt = DATA_W'(set_i_r);
				A_VTRIG: rd_nxt = DATA_W'(vtrig_r);
				A_ITRIG: rd_nxt = DATA_W'(itrig_r);
				A_LCOUNT: rd_nxt = DATA_W'(count_r);
				A_LSKIP: rd_nxt = DATA_W'(skip_r);
				A_LDIR: rd_nxt = DATA_W'(dir_r);
				A_LGEN: rd_nxt = DATA_W'(gen_r);
				A_LPTS: rd_nxt = DATA_W'(pts_r);
				A_LDWELL: rd_nxt = DATA_W'(dwell_r);
				A_MEASV: rd_nxt = DATA_W'({MEAS_EXP, MEAS_V_I});
				A_MEASI: rd_nxt = DATA_W'({MEAS_EXP, MEAS_I_I});
				A_STATUS: rd_nxt = DATA_W'({lst.index, 5'h00,
					lst.running, err_r, armed_r});
				default: rd_nxt = '0;
			endcase
		end
	end

	// Dwell unit divider
	always_comb begin
		tick_nxt = 1'b0;
		tick_cnt_nxt = TICK_W'(tick_cnt_r + 1'b1);
		if (tick_cnt_r == TICK_W'(TICK_CYC_P - 1)) begin
			tick_cnt_nxt = '0;
			tick_nxt = 1'b1;
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rd_r <= '0;
			tick_cnt_r <= '0;
			tick_r <= 1'b0;
		end else begin
			rd_r <= rd_nxt;
			tick_cnt_r <= tick_cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign lst.start = start_r;
	assign lst.stop = stop_r;
	assign lst.dir = dir_r;
	assign lst.tick = tick_r;
	assign lst.count = count_r;
	assign lst.skip = skip_r;
	assign lst.last = IDX_W'(pts_r - 1'b1);
	assign lst.dwell = dwell_r;

	stoc_list_seq u_seq (
		.clk_i(REF_CLK_I),
		.rst_n_i(RST_N_I),
		.lst(lst)
	);

	assign RD_DATA_O = rd_r;
	assign V_PROG_O = v_prog_r;
	assign I_PROG_O = i_prog_r;
	assign OUT_EN_O = out_en_r;
	assign MODE_CURR_O = func_r;
	assign PROT_SEL_O = prot_sel_r;
	assign LIMIT_ERR_O = err_r;
	assign ARMED_O = armed_r;
	assign LIST_RUN_O = lst.running;
	assign LIST_STEP_O = lst.step;
	assign LIST_INDEX_O = lst.index;

	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!RST_N_I);

	property p_prot_gate;
		reg_hit(WR_EN_I, ADDR_I, A_PROT) && !cal_stat_r
			|=> PROT_SEL_O == $past(PROT_SEL_O);
	endproperty
	a_prot_gate: assert property (p_prot_gate)
		else $error("limit select taken outside calibration");

	property p_cal_zero;
		c_zero && cal_stat_r |=> V_PROG_O == '0 && I_PROG_O == '0;
	endproperty
	a_cal_zero: assert property (p_cal_zero)
		else $error("calibration zero left output programmed");

	property p_trig_load;
		fire && !c_zero |=> set_v_r == $past(vtrig_r)
			&& set_i_r == $past(itrig_r) && MODE_CURR_O == $past(tmode_r);
	endproperty
	a_trig_load: assert property (p_trig_load)
		else $error("trigger did not load trigger values");

	property p_trig_consume;
		fire && !cont_r && !c_arm && !reg_hit(WR_EN_I, ADDR_I, A_CONT)
			|=> !ARMED_O;
	endproperty
	a_trig_consume: assert property (p_trig_consume)
		else $error("trigger system still armed after trigger");

	property p_cont_armed;
		cont_r |-> ARMED_O;
	endproperty
	a_cont_armed: assert property (p_cont_armed)
		else $error("continuous arm set but not armed");

	property p_rst_cont;
		c_rst |=> cont_r ##1 ARMED_O;
	endproperty
	a_rst_cont: assert property (p_rst_cont)
		else $error("device reset did not set continuous arm");

	property p_cont_query;
		RD_EN_I && ADDR_I == A_CONT |=> RD_DATA_O == DATA_W'($past(cont_r));
	endproperty
	a_cont_query: assert property (p_cont_query)
		else $error("continuous arm query wrong");

	property p_out_off;
		$fell(OUT_EN_O) |-> V_PROG_O == '0 && I_PROG_O == '0;
	endproperty
	a_out_off: assert property (p_out_off)
		else $error("output disabled but still programmed");

	property p_out_on;
		$rose(OUT_EN_O) |-> V_PROG_O == set_v_r && I_PROG_O == set_i_r;
	endproperty
	a_out_on: assert property (p_out_on)
		else $error("output enable did not restore saved values");

	property p_limit_err;
		MODE_CURR_O == MODE_VOLT && I_LIMIT_I |=> LIMIT_ERR_O;
	endproperty
	a_limit_err: assert property (p_limit_err)
		else $error("current limit in voltage mode not flagged");

	property p_mode_program_mode_a;
		wr_mode |=> vpm_r != PM_TRANSIENT_PROGRAM_MODE && ipm_r != PM_TRANSIENT_PROGRAM_MODE;
	endproperty
	a_mode_program_mode_a: assert property (p_mode_program_mode_a)
		else $error("mode write left transient program mode");

	property p_list_clear;
		c_clr |=> count_r == COUNT_RST && skip_r == SKIP_RST
			&& dir_r == DIR_UP && pts_r == '0;
	endproperty
	a_list_clear: assert property (p_list_clear)
		else $error("list clear did not restore defaults");

	c_trig_fire: cover property (fire ##1 !ARMED_O);
	c_out_cycle: cover property ($fell(OUT_EN_O) ##[1:50] $rose(OUT_EN_O));
	c_err_flag: cover property ($rose(LIMIT_ERR_O));
	c_list_start: cover property ($rose(LIST_RUN_O));
endmodule

// file: dv/stoc_host.sv
// Purpose: Remote host model on the register port.
// Assumes: Strobes one cycle, changed after rising edge.
// Notes: Released lines show inverted values.
`timescale 1ns/10ps
module stoc_host import stoc_pkg::*; (
	// Clock
	input wire logic clk_i,
	// Register port
	output logic [ADDR_W-1:0] addr_o,
	output logic [DATA_W-1:0] wdata_o,
	output logic we_o,
	output logic re_o,
	input wire logic [DATA_W-1:0] rdata_i
);
	initial begin
		addr_o = '0;
		wdata_o = '0;
		we_o = 1'b0;
		re_o = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= v;
		we_o <= 1'b1;
		@(posedge clk_i);
		we_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~v;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_i);
		addr_o <= a;
		re_o <= 1'b1;
		@(posedge clk_i);
		re_o <= 1'b0;
		addr_o <= ~a;
		#1;
		v = rdata_i;
	endtask
endmodule

// file: dv/stoc_bench.sv
// Purpose: Self-checking bench for the command control block.
// Assumes: Dwell tick shortened to 4 cycles.
// Notes: All register traffic goes through the host model.
`timescale 1ns/10ps
module supply_trigger_output_list_control_test;
	import stoc_pkg::*;
	logic clk, rst_n, we, re, trig, vl, il, oe, mc, le, ar, lr, st;
	logic [7:0] a;
	logic [31:0] wd, rdat, d;
	logic [15:0] vp, ip;
	logic [1:0] ps;
	logic [9:0] li;
	int error_cnt = 0;
	int comparisons = 0;
	int cyc = 0;
	stoc_host i_host(.clk_i(clk), .addr_o(a), .wdata_o(wd), .we_o(we),
		.re_o(re), .rdata_i(rdat));
	stoc_top #(.TICK_CYC_P(4)) i_dut(.REF_CLK_I(clk), .RST_N_I(rst_n),
		.ADDR_I(a), .WR_DATA_I(wd), .WR_EN_I(we), .RD_EN_I(re),
		.RD_DATA_O(rdat), .TRIG_I(trig), .V_LIMIT_I(vl), .I_LIMIT_I(il),
		.MEAS_V_I(16'h0123), .MEAS_I_I(16'h0456), .V_PROG_O(vp),
		.I_PROG_O(ip), .OUT_EN_O(oe), .MODE_CURR_O(mc), .PROT_SEL_O(ps),
		.LIMIT_ERR_O(le), .ARMED_O(ar), .LIST_RUN_O(lr), .LIST_STEP_O(st),
		.LIST_INDEX_O(li));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			test_done();
		end
	end
	task automatic test_done();
		if (error_cnt == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic w(input logic [7:0] ad, input logic [31:0] v);
		i_host.wr(ad, v);
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic rc(input logic [7:0] ad, input logic [31:0] e);
		i_host.rd(ad, d);
		chk("read", d, e);
	endtask
	// One-cycle pulse: 0 trigger, 1 voltage limit, else current limit
	task automatic pulse(input int k);
		@(posedge clk);
		case (k)
			0: trig <= 1'b1;
			1: vl <= 1'b1;
			default: il <= 1'b1;
		endcase
		@(posedge clk);
		trig <= 1'b0;
		vl <= 1'b0;
		il <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic t_out();
		chk("oe", oe, 1'b1);
		rc(A_CONT, 1);
		rc(8'h60, 0);
		rc(A_MEASV, {8'h00, MEAS_EXP, 16'h0123});
		rc(A_MEASI, {8'h00, MEAS_EXP, 16'h0456});
		w(A_CMD, 32'h40);
		rc(A_OUTPUT_ENABLE_STATE, 0);
		w(A_VSET, 32'h1234);
		w(A_ISET, 32'h0567);
		chk("vp", vp, 0);
		rc(A_VSET, 32'h1234);
		w(A_OUTPUT_ENABLE_STATE, 1);
		chk("vp", vp, 16'h1234);
		chk("ip", ip, 16'h0567);
		rc(A_OUTPUT_ENABLE_STATE, 1);
		w(A_OUTPUT_ENABLE_STATE, 0);
		chk("vp", vp, 0);
		rc(A_ISET, 32'h0567);
		w(A_CMD, 32'h80);
		chk("ip", ip, 16'h0567);
		w(A_OUTPUT_ENABLE_STATE, 0);
		chk("oe", oe, 1'b1);
	endtask
	task automatic t_trig();
		w(A_CONT, 0);
		rc(A_CONT, 0);
		w(A_VTRIG, 32'h0AAA);
		w(A_ITRIG, 32'h0BBB);
		w(A_TMODE, 1);
		w(A_CMD, 32'h2);
		chk("ar", ar, 1'b1);
		pulse(0);
		chk("vp", vp, 16'h0AAA);
		chk("ar", ar, 1'b0);
		chk("ip", ip, 16'h0BBB);
		chk("mc", mc, 1'b1);
		w(A_VTRIG, 32'h0CCC);
		pulse(0);
		chk("vp", vp, 16'h0AAA);
		w(A_CMD, 32'h20);
		rc(A_CONT, 1);
		pulse(0);
		chk("vp", vp, 16'h0CCC);
	endtask
	task automatic t_cal();
		w(A_PROT, 1);
		chk("ps", ps, SEL_NONE);
		w(A_CAL, 1);
		w(A_PROT, 1);
		chk("ps", ps, SEL_POS);
		w(A_PROT, 0);
		chk("ps", ps, SEL_NEG);
		w(A_CMD, 1);
		chk("vp", {vp, ip}, 0);
		w(A_CAL, 0);
	endtask
	task automatic t_mode();
		w(A_PMODE, 32'h5);
		w(A_FUNC, 1);
		rc(A_PMODE, 0);
		chk("mc", mc, 1'b1);
		rc(A_FUNC, 1);
		rc(A_TMODE, 1);
		w(A_FUNC, 0);
		pulse(1);
		chk("le", le, 1'b0);
		pulse(2);
		chk("le", le, 1'b1);
		w(A_STATUS, 32'h2);
		chk("le", le, 1'b0);
	endtask
	// Counts step pulses from the start of a run to its end
	task automatic run(input logic dir, input logic [9:0] e, input int s);
		int n;
		int k;
		n = 0;
		k = 0;
		w(A_LDIR, {31'h0, dir});
		i_host.wr(A_PMODE, 32'h2);
		@(posedge clk);
		#1;
		chk("lr", lr, 1'b1);
		while (lr === 1'b1 && n < 200) begin
			@(posedge clk);
			#1;
			k += st;
			n++;
		end
		chk("li", li, e);
		chk("steps", k, s);
	endtask
	task automatic t_list();
		w(A_LCOUNT, 32'hFF);
		w(A_LSKIP, 3);
		rc(A_LCOUNT, 32'hFF);
		rc(A_LSKIP, 3);
		w(A_CMD, 32'h8);
		rc(A_LCOUNT, 1);
		rc(A_LSKIP, 0);
		w(A_LPTS, 32'h7D0);
		rc(A_LPTS, 32'h3EA);
		w(A_LDWELL, 32'h0);
		rc(A_LDWELL, 32'h1);
		w(A_LPTS, 3);
		run(1'b0, 10'h2, 3);
		run(1'b1, 10'h0, 3);
		w(A_LCOUNT, 2);
		w(A_LSKIP, 2);
		run(1'b0, 10'h2, 4);
		run(1'b1, 10'h0, 6);
		w(A_LCOUNT, 0);
		w(A_PMODE, 32'h2);
		repeat (40) @(posedge clk);
		#1;
		chk("lr", lr, 1'b1);
		w(A_CMD, 32'h10);
		chk("lr", lr, 1'b0);
		w(A_PMODE, 32'h2);
		w(A_PMODE, 32'h0);
		chk("lr", lr, 1'b0);
	endtask
	initial begin
		rst_n = 1'b0;
		trig = 1'b0;
		vl = 1'b0;
		il = 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_out();
		t_trig();
		t_cal();
		t_mode();
		t_list();
		test_done();
	end
endmodule
